// ### pirq_pkg.sv
// package: register map, field positions, reset values and carrier types
package pirq_pkg;

    // =========================================================
    // register offsets
    localparam logic [7:0] PIRQ_OFS_HEALTH     = 8'h02;
    localparam logic [7:0] PIRQ_OFS_SUP_MASK   = 8'h03;
    localparam logic [7:0] PIRQ_OFS_EVT_MASK   = 8'h04;
    localparam logic [7:0] PIRQ_OFS_SUP_CAUSE  = 8'h05;
    localparam logic [7:0] PIRQ_OFS_EVT_CAUSE  = 8'h06;
    localparam logic [7:0] PIRQ_OFS_FAULT_MASK = 8'h07;
    localparam logic [7:0] PIRQ_OFS_MODE_CTRL  = 8'h08;

    // =========================================================
    // mode_request_control field positions
    localparam int PIRQ_BIT_RESET_REQ   = 0;
    localparam int PIRQ_BIT_DEFAULTS_N  = 1;
    localparam int PIRQ_BIT_SLEEP_REQ   = 6;
    localparam int PIRQ_BIT_STANDBY     = 7;

    // event source positions in event mask and event cause
    localparam int PIRQ_EVT_ADC_LO      = 0;
    localparam int PIRQ_EVT_ADC_HI      = 1;
    localparam int PIRQ_EVT_CHARGER     = 2;
    localparam int PIRQ_EVT_THERMAL     = 3;
    localparam int PIRQ_EVT_PIN_ONE     = 4;
    localparam int PIRQ_EVT_PIN_TWO     = 5;
    localparam int PIRQ_EVT_ANALOG_HIZ  = 6;
    localparam int PIRQ_EVT_ADC_DONE    = 7;

    // =========================================================
    // reset values
    localparam logic [7:0] PIRQ_RST_FAULT_MASK = 8'hFF;
    localparam logic [7:0] PIRQ_RST_SUP_MASK   = 8'h00;
    localparam logic [7:0] PIRQ_RST_EVT_MASK   = 8'h00;
    localparam logic [7:0] PIRQ_RST_CAUSE      = 8'h00;
    localparam logic [7:0] PIRQ_RST_MODE_CTRL  = 8'h00;

    // =========================================================
    // carriers
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pirq_reg_req_type;

    typedef struct packed {
        logic       reset_req;
        logic       sleep_req;
        logic       buck_standby_request;
        logic       supply_fault;
    } pirq_seq_type;

endpackage

// ### pirq_pin_sync.sv
// module: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pirq_pin_sync
    import pirq_pkg::*;
#(
    parameter int WIDTH = 2
)
(
    // clock and control
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    // pins in, filtered levels out
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_level
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } pirq_sync_state_type;

    pirq_sync_state_type st_reg;
    pirq_sync_state_type st_next;

    // =========================================================
    // filter: level moves only when stages two and three agree
    always_comb
    begin
        st_next    = st_reg;
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (st_reg.s2[i] == st_reg.s3[i])
            begin
                st_next.lvl[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st_reg <= '0;
        end
        else if (clk_en)
        begin
            st_reg <= st_next;
        end
    end

    assign pin_level = st_reg.lvl;
endmodule

// ### pirq_toggle_det.sv
// module: per-bit toggle detector against the previous clock's sample
`timescale 1ns/1ps
module pirq_toggle_det
    import pirq_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // clock and control
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    // watched bits and their toggles
    input  wire logic [WIDTH-1:0] watch_in,
    output logic      [WIDTH-1:0] prev_out,
    output logic      [WIDTH-1:0] toggle
);
    typedef struct packed {
        logic             primed;
        logic [WIDTH-1:0] prev;
    } pirq_tog_state_type;

    pirq_tog_state_type st_reg;
    pirq_tog_state_type st_next;

    always_comb
    begin
        st_next.primed = 1'b1;
        st_next.prev   = watch_in;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st_reg <= '0;
        end
        else if (clk_en)
        begin
            st_reg <= st_next;
        end
    end

    // no toggle before the first sample, so reset is not an event
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            assign toggle[g] = st_reg.primed
                               & (watch_in[g] ^ st_reg.prev[g]);
        end
    endgenerate

    assign prev_out = st_reg.prev;
endmodule

// ### pirq_ctrl.sv
// module: sequencing request and host interrupt register block
//
// Contract
// - control bit 0 requests reset, self clears
// - control bit 6 requests sleep, self clears
// - control bit 7 holds bucks in standby
// - defaults flag forced low on defaults reload
// - offset 02 reports supply faults, read only
// - unmasked supply toggle signals fault transition
// - supply fault ignores pending interrupt state
// - offset 03 masks supply interrupt sources
// - offset 04 masks eight event sources
// - set cause bits, then drive line low
// - line low freezes cause, ignores changes
// - host clears supply cause bit, line released
// - no timeout on pending interrupt
// - new interrupt only after line high
// - general pin edges raise interrupts
// - cause registers at 05 and 06
// - system reset low blocks interrupts
// - fault mask resets to all masked
`timescale 1ns/1ps
module pirq_ctrl
    import pirq_pkg::*;
#(
    parameter int NSUP = 8
)
(
    // clock, reset, enable
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    input  wire logic               clk_en,
    // defaults reload strobes and the system reset pin
    input  wire logic               uvlo_reload,
    input  wire logic               hardware_reset_in_n,
    input  wire logic               system_reset_out_n,
    // register access from the serial slave
    input  wire pirq_reg_req_type   reg_req,
    output logic [7:0]              reg_rdata,
    output logic                    reg_rvalid,
    // monitored status
    input  wire logic [NSUP-1:0]    supply_fault_raw,
    input  wire logic               adc_done,
    input  wire logic               analog_hiz,
    input  wire logic               thermal_fault,
    input  wire logic               charger_change,
    input  wire logic               adc_above_high,
    input  wire logic               adc_below_low,
    // general pins and their input configuration
    input  wire logic               general_pin_one,
    input  wire logic               general_pin_two,
    input  wire logic [1:0]         pin_is_input,
    // to the sequencer and the host
    output pirq_seq_type            seq_out,
    output logic                    host_int_n
);
    import pirq_pkg::*;

    // =========================================================
    // state
    typedef struct packed {
        logic [7:0]   health;
        logic [7:0]   sup_mask;
        logic [7:0]   evt_mask;
        logic [7:0]   sup_cause;
        logic [7:0]   evt_cause;
        logic [7:0]   fault_mask;
        logic [7:0]   mode_ctrl;
        logic         pending;
        logic         sys_rst_out_n;
        logic [7:0]   rdata;
        logic         rvalid;
        pirq_seq_type seq;
    } pirq_ctrl_state_type;

    pirq_ctrl_state_type st_reg;
    pirq_ctrl_state_type st_next;

    logic [1:0]  pin_level;
    logic [1:0]  async_lvl;
    logic [7:0]  evt_now;
    logic [7:0]  sup_tog;
    logic [7:0]  evt_tog;
    logic [7:0]  sup_hit;
    logic [7:0]  evt_hit;
    logic        wr_sup_cause;
    logic        defaults_reload;

    // =========================================================
    // pins from outside the clock domain
    pirq_pin_sync #(.WIDTH(2)) u_pins (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .pin_in    ({general_pin_two, general_pin_one}),
        .pin_level (pin_level)
    );

    // reset pins enter inverted, so a freshly cleared sync reads released
    // and no false reload or block follows the block's own reset
    pirq_pin_sync #(.WIDTH(2)) u_resets (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .pin_in    ({~system_reset_out_n, ~hardware_reset_in_n}),
        .pin_level (async_lvl)
    );

    // =========================================================
    // event vector in event mask order
    always_comb
    begin
        evt_now                      = 8'h00;
        evt_now[PIRQ_EVT_ADC_DONE]   = adc_done;
        evt_now[PIRQ_EVT_ANALOG_HIZ] = analog_hiz;
        evt_now[PIRQ_EVT_PIN_TWO]    = pin_level[1] & pin_is_input[1];
        evt_now[PIRQ_EVT_PIN_ONE]    = pin_level[0] & pin_is_input[0];
        evt_now[PIRQ_EVT_THERMAL]    = thermal_fault;
        evt_now[PIRQ_EVT_CHARGER]    = charger_change;
        evt_now[PIRQ_EVT_ADC_HI]     = adc_above_high;
        evt_now[PIRQ_EVT_ADC_LO]     = adc_below_low;
    end

    // status register samples the comparators so toggles are clean
    pirq_toggle_det #(.WIDTH(8)) u_sup_tog (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .watch_in (st_reg.health),
        .prev_out (),
        .toggle   (sup_tog)
    );

    // pin edges of either direction toggle the level
    pirq_toggle_det #(.WIDTH(8)) u_evt_tog (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .watch_in (evt_now),
        .prev_out (),
        .toggle   (evt_tog)
    );

    assign sup_hit = sup_tog & ~st_reg.sup_mask;
    assign evt_hit = evt_tog & ~st_reg.evt_mask;
    assign wr_sup_cause = reg_req.wr && (reg_req.addr == PIRQ_OFS_SUP_CAUSE);
    assign defaults_reload = uvlo_reload | async_lvl[0];

    // =========================================================
    // next state
    always_comb
    begin
        st_next               = st_reg;
        st_next.health        = supply_fault_raw[7:0];
        st_next.sys_rst_out_n = ~async_lvl[1];
        st_next.rvalid        = 1'b0;

        // request bits self clear one clock after they are written
        st_next.mode_ctrl[PIRQ_BIT_RESET_REQ] = 1'b0;
        st_next.mode_ctrl[PIRQ_BIT_SLEEP_REQ] = 1'b0;

        // register writes; status and event cause are read only
        if (reg_req.wr)
        begin
            case (reg_req.addr)
                PIRQ_OFS_SUP_MASK:   st_next.sup_mask   = reg_req.wdata;
                PIRQ_OFS_EVT_MASK:   st_next.evt_mask   = reg_req.wdata;
                PIRQ_OFS_FAULT_MASK: st_next.fault_mask = reg_req.wdata;
                PIRQ_OFS_MODE_CTRL:  st_next.mode_ctrl  = reg_req.wdata;
                PIRQ_OFS_SUP_CAUSE:
                    st_next.sup_cause = st_reg.sup_cause & reg_req.wdata;
                default:             st_next.mode_ctrl  = st_next.mode_ctrl;
            endcase
        end

        // pending clears when a supply cause write clears any set cause bit
        if (st_reg.pending && wr_sup_cause
            && ((st_reg.sup_cause & reg_req.wdata) != st_reg.sup_cause))
        begin
            st_next.pending = 1'b0;
        end

        // capture happens only while the line is high; no timeout path
        if (!st_reg.pending && st_reg.sys_rst_out_n
            && ((sup_hit | evt_hit) != 8'h00))
        begin
            st_next.sup_cause = sup_hit;
            st_next.evt_cause = evt_hit;
            st_next.pending   = 1'b1;
        end
        // while pending, cause contents stay latched apart from clears

        if (!st_reg.sys_rst_out_n)
        begin
            st_next.pending = 1'b0;
        end

        if (defaults_reload)
        begin
            st_next.sup_mask   = PIRQ_RST_SUP_MASK;
            st_next.evt_mask   = PIRQ_RST_EVT_MASK;
            st_next.fault_mask = PIRQ_RST_FAULT_MASK;
            st_next.mode_ctrl  = PIRQ_RST_MODE_CTRL;
            st_next.sup_cause  = PIRQ_RST_CAUSE;
            st_next.evt_cause  = PIRQ_RST_CAUSE;
            st_next.pending    = 1'b0;
            st_next.mode_ctrl[PIRQ_BIT_DEFAULTS_N] = 1'b0;
        end

        // sequencer outputs
        st_next.seq.reset_req = st_reg.mode_ctrl[PIRQ_BIT_RESET_REQ];
        st_next.seq.sleep_req = st_reg.mode_ctrl[PIRQ_BIT_SLEEP_REQ];
        st_next.seq.buck_standby_request =
            st_reg.mode_ctrl[PIRQ_BIT_STANDBY];
        st_next.seq.supply_fault =
            |(sup_tog & ~st_reg.fault_mask);

        // read port: one-cycle answer
        if (reg_req.rd)
        begin
            st_next.rvalid = 1'b1;
            case (reg_req.addr)
                PIRQ_OFS_HEALTH:     st_next.rdata = st_reg.health;
                PIRQ_OFS_SUP_MASK:   st_next.rdata = st_reg.sup_mask;
                PIRQ_OFS_EVT_MASK:   st_next.rdata = st_reg.evt_mask;
                PIRQ_OFS_SUP_CAUSE:  st_next.rdata = st_reg.sup_cause;
                PIRQ_OFS_EVT_CAUSE:  st_next.rdata = st_reg.evt_cause;
                PIRQ_OFS_FAULT_MASK: st_next.rdata = st_reg.fault_mask;
                PIRQ_OFS_MODE_CTRL:  st_next.rdata = st_reg.mode_ctrl;
                default:             st_next.rdata = 8'h00;
            endcase
        end
    end

    // =========================================================
    // registers
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st_reg               <= '0;
            st_reg.fault_mask    <= PIRQ_RST_FAULT_MASK;
            st_reg.sup_mask      <= PIRQ_RST_SUP_MASK;
            st_reg.evt_mask      <= PIRQ_RST_EVT_MASK;
            st_reg.mode_ctrl     <= PIRQ_RST_MODE_CTRL;
        end
        else if (clk_en)
        begin
            st_reg <= st_next;
        end
    end

    // =========================================================
    // outputs, all from flip-flops
    assign reg_rdata  = st_reg.rdata;
    assign reg_rvalid = st_reg.rvalid;
    assign seq_out    = st_reg.seq;
    assign host_int_n = ~st_reg.pending;
endmodule

// ### pirq_ctrl_monitor.sv
// checker: port-level assertions for the interrupt register block
`timescale 1ns/1ps
module pirq_ctrl_monitor
    import pirq_pkg::*;
#(
    parameter int NSUP = 8
)
(
    // clock and reset
    input wire logic             ref_clk,
    input wire logic             sys_rst,
    // watched ports
    input wire logic             clk_en,
    input wire logic             uvlo_reload,
    input wire logic             hardware_reset_in_n,
    input wire logic             system_reset_out_n,
    input wire pirq_reg_req_type reg_req,
    input wire logic             reg_rvalid,
    input wire logic [NSUP-1:0]  supply_fault_raw,
    input wire pirq_seq_type     seq_out,
    input wire logic             host_int_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // =========================================================
    // helpers
    wire ctl_wr = clk_en && reg_req.wr && reg_req.addr == PIRQ_OFS_MODE_CTRL;
    wire clr_wr = clk_en && reg_req.wr && reg_req.addr == PIRQ_OFS_SUP_CAUSE
                  && reg_req.wdata != 8'hFF;
    // pins must be quiet long enough to pass the synchroniser
    sequence pins_quiet;
        (system_reset_out_n && hardware_reset_in_n)[*6];
    endsequence
    sequence no_release;
        !clr_wr && !uvlo_reload;
    endsequence
    // =========================================================
    // assertions
    a_pending_holds: assert property (
        pins_quiet ##0 (!host_int_n and no_release)
        ##1 no_release |-> !host_int_n)
        else $error("interrupt line released without a clearing write");
    a_reset_pulse: assert property (ctl_wr && reg_req.wdata[0] && !uvlo_reload
        |-> ##2 seq_out.reset_req ##1 !seq_out.reset_req)
        else $error("reset request pulse missing or too long");
    a_sleep_pulse: assert property (ctl_wr && reg_req.wdata[6] && !uvlo_reload
        |-> ##2 seq_out.sleep_req ##1 !seq_out.sleep_req)
        else $error("sleep request pulse missing or too long");
    a_standby_set: assert property (ctl_wr && !uvlo_reload
        |-> ##2 seq_out.buck_standby_request == $past(reg_req.wdata[7], 2))
        else $error("standby level does not follow control bit");
    a_read_answer: assert property (clk_en && reg_req.rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_req.rd))
        else $error("read answer without a read");
    a_fault_cause: assert property (seq_out.supply_fault
        |-> $past(supply_fault_raw, 2) != $past(supply_fault_raw, 3))
        else $error("supply fault without a status toggle");
    // seven samples: three sync stages, the level, the state bit, the pending bit, the line
    a_blocked_high: assert property (
        !system_reset_out_n[*7] |-> host_int_n)
        else $error("interrupt asserted while system reset low");
endmodule

bind pirq_ctrl pirq_ctrl_monitor #(.NSUP(NSUP)) u_mon (.*);

// ### pirq_host_model.sv
// partner: host processor driving the register port
`timescale 1ns/1ps
module pirq_host_model
    import pirq_pkg::*;
(
    // clock
    input  wire logic        ref_clk,
    // register port
    output pirq_reg_req_type reg_req,
    input  wire logic [7:0]  reg_rdata,
    input  wire logic        reg_rvalid
);
    initial reg_req = '0;
    // =========================================================
    // one request per call; released address and data are inverted
    // so a design that samples late sees garbage, not a stale match
    task automatic put(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_req = '{wr: w, rd: ~w, addr: a, wdata: d};
        @(posedge ref_clk);
        #1;
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // only used once the bench has left reset
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        put(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic ok);
        put(1'b0, a, 8'h00);
        ok = reg_rvalid;
        d = reg_rdata;
    endtask
endmodule

// ### tb_pirq_ctrl.sv
// testbench: register map, interrupt line and sequencing requests
`timescale 1ns/1ps
module tb_pirq_ctrl;
    import pirq_pkg::*;
    // =========================================================
    // design ports and bench state
    logic             ref_clk = 1'b0;
    logic             sys_rst = 1'b1;
    logic             clk_en = 1'b1;
    logic             uvlo_reload = 1'b0;
    logic             hardware_reset_in_n = 1'b1;
    logic             system_reset_out_n = 1'b1;
    pirq_reg_req_type reg_req;
    logic [7:0]       reg_rdata;
    logic             reg_rvalid;
    logic [7:0]       supply_fault_raw = 8'h00;
    logic [7:0]       evt = 8'h00;
    logic             adc_done, analog_hiz, thermal_fault, charger_change;
    logic             adc_above_high, adc_below_low;
    logic             general_pin_one, general_pin_two;
    logic [1:0]       pin_is_input = 2'b11;
    pirq_seq_type     seq_out;
    logic             host_int_n;
    int               n_mismatch, compares, cyc, n_rst, n_slp, n_flt;
    int               mdl [2:8];
    integer           seed = 32'hD8B7BE07;
    assign {adc_done, analog_hiz, general_pin_two, general_pin_one,
            thermal_fault, charger_change, adc_above_high, adc_below_low} = evt;
    pirq_ctrl #(.NSUP(8)) DUT (.*);
    pirq_host_model host (.*);
    initial forever #5 ref_clk = ~ref_clk;
    // =========================================================
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp,
                       input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rdc(input logic [7:0] a);
        logic [7:0] d;
        logic       ok;
        host.rd(a, d, ok);
        chk("read answer", 8'h01, {7'h00, ok});
        chk($sformatf("reg %h", a),
            (a inside {[2:8]}) ? 8'(mdl[a]) : 8'h00, d);
    endtask
    task automatic rdall();
        for (int a = 2; a <= 8; a++) rdc(8'(a));
    endtask
    task automatic line(input logic exp);
        chk("int line", {7'h00, exp}, {7'h00, host_int_n});
    endtask
    task automatic dflt();
        mdl = '{default: 0};
        mdl[7] = 8'hFF;
        mdl[2] = supply_fault_raw;
    endtask
    task automatic reload();
        uvlo_reload = 1'b1;
        tick(1);
        uvlo_reload = 1'b0;
        dflt();
        tick(4);
    endtask
    task automatic flip(input int k);
        supply_fault_raw[k] = ~supply_fault_raw[k];
        mdl[2] = supply_fault_raw;
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // pulse counters and hang guard
    always @(posedge ref_clk)
    begin
        cyc++;
        if (seq_out.reset_req === 1'b1) n_rst++;
        if (seq_out.sleep_req === 1'b1) n_slp++;
        if (seq_out.supply_fault === 1'b1) n_flt++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            conclude();
        end
    end
    // =========================================================
    // scenarios
    initial
    begin
        logic [7:0] d;
        int         f, k;
        dflt();
        tick(20);
        sys_rst = 1'b0;
        rdall();
        rdc(8'h20);
        $display("test reset_values finished");
        // a write while the enable is low must leave no trace
        tick(1);
        clk_en = 1'b0;
        host.wr(PIRQ_OFS_SUP_MASK, 8'h55);
        clk_en = 1'b1;
        rdc(PIRQ_OFS_SUP_MASK);
        for (int a = 2; a <= 7; a++)
        begin
            d = 8'($random(seed));
            host.wr(8'(a), d);
            if (a inside {3, 4, 7}) mdl[a] = d;
        end
        rdall();
        $display("test register_access finished");
        host.wr(PIRQ_OFS_MODE_CTRL, 8'h81);
        mdl[8] = 8'h80;
        rdc(PIRQ_OFS_MODE_CTRL);
        host.wr(PIRQ_OFS_MODE_CTRL, 8'hC2);
        mdl[8] = 8'h82;
        rdc(PIRQ_OFS_MODE_CTRL);
        chk("reset pulses", 8'h01, 8'(n_rst));
        chk("sleep pulses", 8'h01, 8'(n_slp));
        chk("standby", 8'h01, {7'h00, seq_out.buck_standby_request});
        reload();
        rdall();
        host.wr(PIRQ_OFS_MODE_CTRL, 8'h02);
        mdl[8] = 8'h02;
        rdc(PIRQ_OFS_MODE_CTRL);
        hardware_reset_in_n = 1'b0;
        tick(8);
        hardware_reset_in_n = 1'b1;
        dflt();
        tick(6);
        rdall();
        chk("standby", 8'h00, {7'h00, seq_out.buck_standby_request});
        $display("test control finished");
        host.wr(PIRQ_OFS_FAULT_MASK, 8'h00);
        mdl[7] = 0;
        for (k = 0; k < 8; k++)
        begin
            f = n_flt;
            flip(k);
            tick(4);
            line(1'b0);
            mdl[5] = 1 << k;
            flip((k + 1) % 8);
            tick(4);
            rdc(PIRQ_OFS_SUP_CAUSE);
            rdc(PIRQ_OFS_HEALTH);
            chk("fault pulses", 8'h02, 8'(n_flt - f));
            host.wr(PIRQ_OFS_SUP_CAUSE, 8'hFF);
            tick(3);
            line(1'b0);
            host.wr(PIRQ_OFS_SUP_CAUSE, 8'h00);
            mdl[5] = 0;
            tick(4);
            line(1'b1);
            rdc(PIRQ_OFS_SUP_CAUSE);
        end
        host.wr(PIRQ_OFS_SUP_MASK, 8'hFF);
        host.wr(PIRQ_OFS_FAULT_MASK, 8'hFF);
        f = n_flt;
        flip($random(seed) & 7);
        tick(8);
        line(1'b1);
        chk("masked faults", 8'h00, 8'(n_flt - f));
        $display("test supply_interrupt finished");
        reload();
        for (int i = 0; i < 16; i++)
        begin
            evt[i % 8] = ~evt[i % 8];
            tick(10);
            line(1'b0);
            mdl[6] = 1 << (i % 8);
            rdc(PIRQ_OFS_EVT_CAUSE);
            reload();
        end
        host.wr(PIRQ_OFS_EVT_MASK, 8'hFF);
        evt = ~evt;
        tick(10);
        line(1'b1);
        // pins configured as outputs raise nothing, even unmasked
        pin_is_input = 2'b00;
        tick(2);
        host.wr(PIRQ_OFS_EVT_MASK, 8'h00);
        evt[PIRQ_EVT_PIN_ONE] = ~evt[PIRQ_EVT_PIN_ONE];
        tick(10);
        line(1'b1);
        $display("test event_interrupt finished");
        reload();
        system_reset_out_n = 1'b0;
        tick(6);
        flip(0);
        tick(8);
        line(1'b1);
        system_reset_out_n = 1'b1;
        tick(6);
        $display("test blocked_interrupt finished");
        conclude();
    end
endmodule
